// ---- logic/hpc_i2c_slave.v ----
// Write/read register slave on the two-wire serial bus
`timescale 1ns/1ps
`default_nettype none
`include "hpc_regs.vh"
module hpc_i2c_slave (
	// Clock and reset
	input wire clock_i,
	input wire srst_i,
	// Bus pins
	input wire scl_i,
	input wire sda_i,
	output wire sda_o,
	output wire sda_oe_o,
	// Register port
	output reg wr_stb_o,
	output reg [7:0] wr_addr_o,
	output reg [7:0] wr_data_o,
	output wire [7:0] rd_addr_o,
	input wire [7:0] rd_data_i
);
	localparam ST_IDLE = 5'h01;
	localparam ST_DEVA = 5'h02;
	localparam ST_REGA = 5'h04;
	localparam ST_DATA = 5'h08;
	localparam ST_READ = 5'h10;

	////////////////////////////////////////////////////////////////
	// Three-stage pin filter
	reg [2:0] scl_sync_ff;
	reg [2:0] sda_sync_ff;
	reg scl_ff;
	reg sda_ff;
	always @(posedge clock_i) begin
		if (srst_i) begin
			scl_sync_ff <= 3'h7;
			sda_sync_ff <= 3'h7;
			scl_ff <= 1'b1;
			sda_ff <= 1'b1;
		end else begin
			scl_sync_ff <= {scl_sync_ff[1:0], scl_i};
			sda_sync_ff <= {sda_sync_ff[1:0], sda_i};
			if (scl_sync_ff[1] == scl_sync_ff[2])
				scl_ff <= scl_sync_ff[2];
			if (sda_sync_ff[1] == sda_sync_ff[2])
				sda_ff <= sda_sync_ff[2];
		end
	end
	wire scl_now = (scl_sync_ff[1] == scl_sync_ff[2]) ? scl_sync_ff[2] : scl_ff;
	wire sda_now = (sda_sync_ff[1] == sda_sync_ff[2]) ? sda_sync_ff[2] : sda_ff;
	wire scl_rise = scl_now & ~scl_ff;
	wire scl_fall = ~scl_now & scl_ff;
	wire start_ev = scl_ff & scl_now & sda_ff & ~sda_now;
	wire stop_ev = scl_ff & scl_now & ~sda_ff & sda_now;

	////////////////////////////////////////////////////////////////
	// Byte engine
	reg [4:0] state_ff;
	reg [3:0] bit_cnt_ff;
	reg [7:0] shift_ff;
	reg ack_ff;
	reg drive_ff;
	reg [7:0] ptr_ff;
	assign rd_addr_o = ptr_ff;
	assign sda_o = 1'b0;
	assign sda_oe_o = drive_ff;
	always @(posedge clock_i) begin
		if (srst_i) begin
			state_ff <= ST_IDLE;
			bit_cnt_ff <= 4'h0;
			shift_ff <= 8'h00;
			ack_ff <= 1'b0;
			drive_ff <= 1'b0;
			ptr_ff <= 8'h00;
			wr_stb_o <= 1'b0;
			wr_addr_o <= 8'h00;
			wr_data_o <= 8'h00;
		end else begin
			wr_stb_o <= 1'b0;
			if (start_ev) begin
				state_ff <= ST_DEVA;
				bit_cnt_ff <= 4'h0;
				ack_ff <= 1'b0;
				drive_ff <= 1'b0;
			end else if (stop_ev) begin
				state_ff <= ST_IDLE;
				drive_ff <= 1'b0;
			end else if (state_ff != ST_IDLE && scl_rise && !ack_ff) begin
				shift_ff <= {shift_ff[6:0], sda_now};
				bit_cnt_ff <= bit_cnt_ff + 4'h1;
			end else if (state_ff != ST_IDLE && scl_fall) begin
				if (ack_ff) begin
					ack_ff <= 1'b0;
					bit_cnt_ff <= 4'h0;
					drive_ff <= (state_ff == ST_READ) ? ~rd_data_i[7] : 1'b0;
					shift_ff <= rd_data_i;
				end else if (state_ff == ST_READ) begin
					if (bit_cnt_ff == 4'h8) begin
						drive_ff <= 1'b0;
						ptr_ff <= ptr_ff + 8'h01;
						state_ff <= ST_IDLE;
					end else
						drive_ff <= ~shift_ff[7];
				end else if (bit_cnt_ff == 4'h8) begin
					case (state_ff)
					ST_DEVA: begin
						if (shift_ff[7:1] == `HPC_DEV_ADDR) begin
							ack_ff <= 1'b1;
							drive_ff <= 1'b1;
							state_ff <= shift_ff[0] ? ST_READ : ST_REGA;
						end else
							state_ff <= ST_IDLE;
					end
					ST_REGA: begin
						ptr_ff <= shift_ff;
						ack_ff <= 1'b1;
						drive_ff <= 1'b1;
						state_ff <= ST_DATA;
					end
					ST_DATA: begin
						wr_stb_o <= 1'b1;
						wr_addr_o <= ptr_ff;
						wr_data_o <= shift_ff;
						ptr_ff <= ptr_ff + 8'h01;
						ack_ff <= 1'b1;
						drive_ff <= 1'b1;
					end
					default: state_ff <= ST_IDLE;
					endcase
				end
			end
		end
	end
endmodule // hpc_i2c_slave
`default_nettype wire

// ---- logic/hpc_power_ctrl.v ----
// Top of the headphone amp power control block
`timescale 1ns/1ps
`default_nettype none
`include "hpc_regs.vh"
module hpc_power_ctrl #(
	parameter [15:0] RAIL_HOLD_CYC = `HPC_RAIL_HOLD_DEF,
	parameter [15:0] STEP_CYC = `HPC_STEP_CYC_DEF,
	parameter [15:0] PDN_CYC = `HPC_PDN_CYC
) (
	// Clock and reset
	input wire clock_i,
	input wire srst_i,
	// Serial bus
	input wire scl_i,
	input wire sda_i,
	output wire sda_o,
	output wire sda_oe_o,
	// Analog status inputs
	input wire supply_ok_i,
	input wire sig_high_i,
	input wire out_high_i,
	input wire peak_over_i,
	input wire zero_cur_i,
	input wire thermal_i,
	// Converter controls
	output reg high_sw_o,
	output reg low_sw_o,
	output reg rail_high_o,
	output reg [1:0] cur_limit_o,
	output reg soft_start_o,
	// Amplifier controls
	output reg left_amp_on_o,
	output reg right_amp_on_o,
	output reg left_mute_o,
	output reg right_mute_o,
	output reg [4:0] volume_o,
	output reg distortion_reduce_mode_o,
	output reg left_hiz_o,
	output reg right_hiz_o,
	output reg shutdown_busy_o
);
	localparam SW_IDLE = 4'h1;
	localparam SW_HIGH = 4'h2;
	localparam SW_LOW = 4'h4;
	localparam SW_DRAIN = 4'h8;

	////////////////////////////////////////////////////////////////
	// Pin filter for analog comparator inputs
	function [2:0] shift3;
		input [2:0] v;
		input b;
		shift3 = {v[1:0], b};
	endfunction
	reg [2:0] sup_s_ff, sig_s_ff, out_s_ff, pk_s_ff, zc_s_ff, th_s_ff;
	reg sup_ff, sig_ff, out_ff, pk_ff, zc_ff, th_ff;
	always @(posedge clock_i) begin
		if (srst_i) begin
			sup_s_ff <= 3'h0;
			sig_s_ff <= 3'h0;
			out_s_ff <= 3'h0;
			pk_s_ff <= 3'h0;
			zc_s_ff <= 3'h0;
			th_s_ff <= 3'h0;
			sup_ff <= 1'b0;
			sig_ff <= 1'b0;
			out_ff <= 1'b0;
			pk_ff <= 1'b0;
			zc_ff <= 1'b0;
			th_ff <= 1'b0;
		end else begin
			sup_s_ff <= shift3(sup_s_ff, supply_ok_i);
			sig_s_ff <= shift3(sig_s_ff, sig_high_i);
			out_s_ff <= shift3(out_s_ff, out_high_i);
			pk_s_ff <= shift3(pk_s_ff, peak_over_i);
			zc_s_ff <= shift3(zc_s_ff, zero_cur_i);
			th_s_ff <= shift3(th_s_ff, thermal_i);
			if (sup_s_ff[1] == sup_s_ff[2]) sup_ff <= sup_s_ff[2];
			if (sig_s_ff[1] == sig_s_ff[2]) sig_ff <= sig_s_ff[2];
			if (out_s_ff[1] == out_s_ff[2]) out_ff <= out_s_ff[2];
			if (pk_s_ff[1] == pk_s_ff[2]) pk_ff <= pk_s_ff[2];
			if (zc_s_ff[1] == zc_s_ff[2]) zc_ff <= zc_s_ff[2];
			if (th_s_ff[1] == th_s_ff[2]) th_ff <= th_s_ff[2];
		end
	end

	////////////////////////////////////////////////////////////////
	// Register file
	wire wr_stb;
	wire [7:0] wr_addr;
	wire [7:0] wr_data;
	wire [7:0] rd_addr;
	reg [7:0] rd_data;
	reg [7:0] pwr_ff;
	reg [7:0] mute_ff;
	reg [7:0] opt_ff;

	hpc_i2c_slave u_bus (
		.clock_i(clock_i),
		.srst_i(srst_i),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.sda_o(sda_o),
		.sda_oe_o(sda_oe_o),
		.wr_stb_o(wr_stb),
		.wr_addr_o(wr_addr),
		.wr_data_o(wr_data),
		.rd_addr_o(rd_addr),
		.rd_data_i(rd_data)
	);

	always @(posedge clock_i) begin
		if (srst_i) begin
			pwr_ff <= `HPC_PWR_RESET;
			mute_ff <= `HPC_MUTE_RESET;
			opt_ff <= `HPC_OPT_RESET;
		end else if (wr_stb) begin
			case (wr_addr)
			`HPC_REG_PWR: pwr_ff <= wr_data & `HPC_PWR_MASK;
			`HPC_REG_MUTE: mute_ff <= wr_data & `HPC_MUTE_MASK;
			`HPC_REG_OPT: opt_ff <= wr_data & `HPC_OPT_MASK;
			default: ;
			endcase
		end
	end

	always @* begin
		case (rd_addr)
		`HPC_REG_PWR: rd_data = pwr_ff | {6'h00, th_ff, 1'b0};
		`HPC_REG_MUTE: rd_data = mute_ff;
		`HPC_REG_OPT: rd_data = opt_ff;
		`HPC_REG_INFO: rd_data = `HPC_INFO_VALUE;
		default: rd_data = 8'h00;
		endcase
	end

	wire pdn = pwr_ff[`HPC_BIT_PDN];

	////////////////////////////////////////////////////////////////
	// Shutdown sequence timer and soft start
	reg pdn_d_ff;
	reg [15:0] pdn_cnt_ff;
	reg [15:0] step_cnt_ff;
	reg running_ff;
	always @(posedge clock_i) begin
		if (srst_i) begin
			pdn_d_ff <= 1'b1;
			pdn_cnt_ff <= 16'h0000;
			step_cnt_ff <= 16'h0000;
			running_ff <= 1'b0;
			shutdown_busy_o <= 1'b0;
			soft_start_o <= 1'b0;
			cur_limit_o <= `HPC_LIM_70MA;
		end else begin
			pdn_d_ff <= pdn;
			if (pdn && !pdn_d_ff) begin
				pdn_cnt_ff <= PDN_CYC - 16'h0001;
				shutdown_busy_o <= 1'b1;
			end else if (pdn_cnt_ff != 16'h0000)
				pdn_cnt_ff <= pdn_cnt_ff - 16'h0001;
			else
				shutdown_busy_o <= 1'b0;
			if (pdn) begin
				running_ff <= 1'b0;
				soft_start_o <= 1'b0;
				cur_limit_o <= `HPC_LIM_70MA;
			end else if (pdn_d_ff && sup_ff) begin
				running_ff <= 1'b1;
				soft_start_o <= 1'b1;
				cur_limit_o <= `HPC_LIM_70MA;
				step_cnt_ff <= STEP_CYC;
			end else if (soft_start_o) begin
				if (step_cnt_ff != 16'h0000)
					step_cnt_ff <= step_cnt_ff - 16'h0001;
				else begin
					step_cnt_ff <= STEP_CYC;
					cur_limit_o <= cur_limit_o + 2'h1;
					if (cur_limit_o == `HPC_LIM_280MA)
						soft_start_o <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Class G rail selection
	reg [15:0] hold_cnt_ff;
	always @(posedge clock_i) begin
		if (srst_i || !running_ff) begin
			rail_high_o <= 1'b0;
			hold_cnt_ff <= 16'h0000;
		end else if (sig_ff) begin
			rail_high_o <= 1'b1;
			hold_cnt_ff <= RAIL_HOLD_CYC;
		end else if (hold_cnt_ff != 16'h0000)
			hold_cnt_ff <= hold_cnt_ff - 16'h0001;
		else
			rail_high_o <= 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// Pulse mode switch sequencer
	reg [3:0] sw_ff;
	always @(posedge clock_i) begin
		if (srst_i || !running_ff) begin
			sw_ff <= SW_IDLE;
			high_sw_o <= 1'b0;
			low_sw_o <= 1'b0;
		end else begin
			case (sw_ff)
			SW_IDLE: begin
				low_sw_o <= 1'b0;
				if (!out_ff) begin
					sw_ff <= SW_HIGH;
					high_sw_o <= 1'b1;
				end
			end
			SW_HIGH: begin
				if (out_ff) begin
					high_sw_o <= 1'b0;
					low_sw_o <= 1'b1;
					sw_ff <= SW_DRAIN;
				end else if (pk_ff) begin
					high_sw_o <= 1'b0;
					low_sw_o <= 1'b1;
					sw_ff <= SW_LOW;
				end
			end
			SW_LOW: begin
				if (zc_ff) begin
					low_sw_o <= 1'b0;
					if (!out_ff) begin
						high_sw_o <= 1'b1;
						sw_ff <= SW_HIGH;
					end else
						sw_ff <= SW_IDLE;
				end
			end
			SW_DRAIN: begin
				if (zc_ff) begin
					low_sw_o <= 1'b0;
					sw_ff <= SW_IDLE;
				end
			end
			default: begin
				sw_ff <= SW_IDLE;
				high_sw_o <= 1'b0;
				low_sw_o <= 1'b0;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Amplifier control outputs
	always @(posedge clock_i) begin
		if (srst_i) begin
			left_amp_on_o <= 1'b0;
			right_amp_on_o <= 1'b0;
			left_mute_o <= 1'b1;
			right_mute_o <= 1'b1;
			volume_o <= 5'h00;
			distortion_reduce_mode_o <= 1'b0;
			left_hiz_o <= 1'b0;
			right_hiz_o <= 1'b0;
		end else begin
			left_amp_on_o <= ~pdn & pwr_ff[`HPC_BIT_LEFT];
			right_amp_on_o <= ~pdn & pwr_ff[`HPC_BIT_RIGHT];
			left_mute_o <= mute_ff[`HPC_BIT_LEFT];
			right_mute_o <= mute_ff[`HPC_BIT_RIGHT];
			volume_o <= mute_ff[5:1];
			distortion_reduce_mode_o <= opt_ff[`HPC_BIT_LOWD];
			left_hiz_o <= opt_ff[`HPC_BIT_HIZL];
			right_hiz_o <= opt_ff[`HPC_BIT_HIZR];
		end
	end
endmodule // hpc_power_ctrl
`default_nettype wire

// ---- logic/hpc_regs.vh ----
// Register map and timing constants for the headphone amp power control block
`ifndef HPC_REGS_VH
`define HPC_REGS_VH

`define HPC_DEV_ADDR 7'h60
`define HPC_REG_PWR 8'h01
`define HPC_REG_MUTE 8'h02
`define HPC_REG_OPT 8'h03
`define HPC_REG_INFO 8'h04
`define HPC_PWR_RESET 8'h01
`define HPC_MUTE_RESET 8'hc0
`define HPC_OPT_RESET 8'h00
`define HPC_INFO_VALUE 8'h5a // Arbitrary value
`define HPC_PWR_MASK 8'hc1
`define HPC_MUTE_MASK 8'hfe
`define HPC_OPT_MASK 8'h0b
`define HPC_BIT_PDN 0
`define HPC_BIT_THRM 1
`define HPC_BIT_RIGHT 6
`define HPC_BIT_LEFT 7
`define HPC_BIT_LOWD 3
`define HPC_BIT_HIZL 1
`define HPC_BIT_HIZR 0
`define HPC_CLK_KHZ 10000
`define HPC_PDN_US 3000
`define HPC_PDN_CYC ((`HPC_PDN_US * `HPC_CLK_KHZ) / 1000)
`define HPC_RAIL_HOLD_DEF 16'd1000
`define HPC_STEP_CYC_DEF 16'd500
`define HPC_LIM_70MA 2'h0
`define HPC_LIM_140MA 2'h1
`define HPC_LIM_280MA 2'h2
`define HPC_LIM_750MA 2'h3

`endif

// ---- sim/hpc_bus_host.sv ----
// Serial bus host model for register access
`timescale 1ns/1ps
`default_nettype none
`include "hpc_regs.vh"
module hpc_bus_host (
	// Clock
	input wire logic clock_i,
	// Bus
	input wire logic sda_i,
	output logic scl_o,
	output logic pull_o
);
	initial begin
		scl_o = 1'b1;
		pull_o = 1'b0;
	end
	task automatic hold;
		repeat (8) @(posedge clock_i);
	endtask
	task automatic start;
		pull_o <= 1'b0;
		hold();
		scl_o <= 1'b1;
		hold();
		pull_o <= 1'b1;
		hold();
		scl_o <= 1'b0;
	endtask
	task automatic stop;
		hold();
		pull_o <= 1'b1;
		hold();
		scl_o <= 1'b1;
		hold();
		pull_o <= 1'b0;
		hold();
	endtask
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
		for (int i = 8; i >= 0; i--) begin
			hold();
			pull_o <= (i > 0) ? ~tx[i - 1] : 1'b0;
			hold();
			scl_o <= 1'b1;
			hold();
			if (i > 0)
				rx[i - 1] = sda_i;
			else
				ack = ~sda_i;
			scl_o <= 1'b0;
		end
	endtask
	// Address, register, data, each answered before stop
	task automatic wr(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] wd,
		output logic [2:0] ak);
		logic [7:0] rx;
		start();
		xfer({dev, 1'b0}, rx, ak[2]);
		xfer(ra, rx, ak[1]);
		xfer(wd, rx, ak[0]);
		stop();
	endtask
	task automatic rd(input logic [7:0] ra, output logic [7:0] rd_o);
		logic [7:0] rx;
		logic a;
		start();
		xfer({`HPC_DEV_ADDR, 1'b0}, rx, a);
		xfer(ra, rx, a);
		start();
		xfer({`HPC_DEV_ADDR, 1'b1}, rx, a);
		xfer(8'hff, rd_o, a);
		stop();
	endtask
endmodule // hpc_bus_host
`default_nettype wire

// ---- sim/hpc_power_ctrl_asserts.sv ----
// Port checks for the headphone amp power control block
`timescale 1ns/1ps
`default_nettype none
module hpc_power_ctrl_asserts #(
	parameter [15:0] RAIL_HOLD_CYC = 16'd10,
	parameter [15:0] STEP_CYC = 16'd5,
	parameter [15:0] PDN_CYC = 16'd20
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic srst_i,
	// Status inputs
	input wire logic supply_ok_i,
	input wire logic sig_high_i,
	input wire logic out_high_i,
	input wire logic zero_cur_i,
	// Watched outputs
	input wire logic high_sw_o,
	input wire logic low_sw_o,
	input wire logic rail_high_o,
	input wire logic [1:0] cur_limit_o,
	input wire logic soft_start_o,
	input wire logic left_amp_on_o,
	input wire logic right_amp_on_o,
	input wire logic shutdown_busy_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (srst_i);
	logic [15:0] busy_cnt, low_cnt, dwell_cnt;
	////////////////////////////////////////////////////////////////////////////
	// Run lengths
	always @(posedge clock_i) begin
		busy_cnt <= (srst_i || !shutdown_busy_o) ? 16'h0 : busy_cnt + 16'h1;
		low_cnt <= (srst_i || sig_high_i) ? 16'h0 : low_cnt + {15'h0, low_cnt != 16'hffff};
		dwell_cnt <= (srst_i || $changed(cur_limit_o)) ? 16'h0 : dwell_cnt + 16'h1;
	end
	sequence step_up;
		$changed(cur_limit_o) && cur_limit_o >= 2'h2;
	endsequence
	sequence ramp_end;
		$fell(soft_start_o);
	endsequence
	////////////////////////////////////////////////////////////////////////////
	// Assertions
	chk_busy_len: assert property ($fell(shutdown_busy_o) |-> busy_cnt == PDN_CYC)
		else $error("busy length wrong");
	chk_pdn_off: assert property (shutdown_busy_o [*2] |-> !high_sw_o && !low_sw_o
		&& !left_amp_on_o && !right_amp_on_o)
		else $error("outputs on in power-down");
	chk_sw_excl: assert property (!(high_sw_o && low_sw_o))
		else $error("both switches on");
	chk_hs_stop: assert property (out_high_i [*8] |-> !high_sw_o)
		else $error("high switch on above threshold");
	chk_ls_zero: assert property (zero_cur_i [*8] |-> !(low_sw_o && $past(low_sw_o)))
		else $error("low switch on at zero current");
	chk_rail_rise: assert property ($rose(rail_high_o) |-> $past(sig_high_i, 3))
		else $error("rail rose without signal");
	chk_rail_hold: assert property ($fell(rail_high_o) |-> low_cnt > RAIL_HOLD_CYC
		&& low_cnt <= RAIL_HOLD_CYC + 16'd8)
		else $error("rail hold wrong");
	chk_step_dwell: assert property (step_up |-> dwell_cnt >= STEP_CYC
		&& dwell_cnt <= STEP_CYC + 16'h1 && cur_limit_o == $past(cur_limit_o) + 2'h1)
		else $error("limit step wrong");
	chk_ramp_top: assert property (ramp_end |-> cur_limit_o == 2'h3)
		else $error("ramp ended below top limit");
	chk_start_gate: assert property ($rose(soft_start_o) |-> $past(supply_ok_i, 4))
		else $error("start without supply");
endmodule // hpc_power_ctrl_asserts
`default_nettype wire

// ---- sim/tb_headphone_amp_power_control.sv ----
// Self-checking bench for the headphone amp power control block
`timescale 1ns/1ps
`default_nettype none
`include "hpc_regs.vh"
module tb_headphone_amp_power_control;
	localparam [15:0] RH = 16'd10;
	localparam [15:0] SC = 16'd5;
	localparam [15:0] SD = 16'd20;
	logic clock_i = 1'b0, srst_i = 1'b1, supply_ok_i = 1'b0, sig_high_i = 1'b0;
	logic out_high_i = 1'b1, peak_over_i = 1'b0, zero_cur_i = 1'b1, scl, pull;
	wire logic sda_o, sda_oe_o, high_sw_o, low_sw_o, rail_high_o, soft_start_o;
	wire logic left_amp_on_o, right_amp_on_o, left_mute_o, right_mute_o, shutdown_busy_o;
	wire logic distortion_reduce_mode_o, left_hiz_o, right_hiz_o;
	wire logic [1:0] cur_limit_o;
	wire logic [4:0] volume_o;
	wire logic sda = ~(pull | (sda_oe_o & ~sda_o));
	logic [3:0] lim_seen = 4'h0;
	logic [7:0] busy_n = 8'h0;
	logic [7:0] rst_tab [1:5] = '{8'h01, 8'hc0, 8'h00, `HPC_INFO_VALUE, 8'h00};
	integer fails, tests_run, seed = 89;
	always #50 clock_i = ~clock_i;
	always @(posedge clock_i) begin
		if (soft_start_o === 1'b1)
			lim_seen[cur_limit_o] <= 1'b1;
		if (shutdown_busy_o === 1'b1)
			busy_n <= busy_n + 8'h1;
	end
	hpc_bus_host host_u (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .pull_o(pull));
	hpc_power_ctrl #(.RAIL_HOLD_CYC(RH), .STEP_CYC(SC), .PDN_CYC(SD)) dut_u (
		.clock_i(clock_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe_o(sda_oe_o), .supply_ok_i(supply_ok_i), .sig_high_i(sig_high_i),
		.out_high_i(out_high_i), .peak_over_i(peak_over_i), .zero_cur_i(zero_cur_i),
		.thermal_i(1'b0), .high_sw_o(high_sw_o), .low_sw_o(low_sw_o),
		.rail_high_o(rail_high_o), .cur_limit_o(cur_limit_o), .soft_start_o(soft_start_o),
		.left_amp_on_o(left_amp_on_o), .right_amp_on_o(right_amp_on_o),
		.left_mute_o(left_mute_o), .right_mute_o(right_mute_o), .volume_o(volume_o),
		.distortion_reduce_mode_o(distortion_reduce_mode_o), .left_hiz_o(left_hiz_o),
		.right_hiz_o(right_hiz_o), .shutdown_busy_o(shutdown_busy_o));
	////////////////////////////////////////////////////////////////////////////
	// Checking helpers
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [7:0] exp_rd(input logic [7:0] ra, input logic [7:0] d);
		case (ra)
			`HPC_REG_PWR: exp_rd = d & `HPC_PWR_MASK;
			`HPC_REG_OPT: exp_rd = d & `HPC_OPT_MASK;
			default: exp_rd = d & `HPC_MUTE_MASK;
		endcase
	endfunction
	function automatic logic probe(input int sel);
		probe = (sel == 0) ? high_sw_o : (sel == 1) ? low_sw_o : rail_high_o;
	endfunction
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wait_lvl(input int sel, input logic v, input int lim);
		for (int n = 0; n < lim && probe(sel) !== v; n++)
			@(negedge clock_i);
		check("switch or rail", {7'h0, probe(sel)}, {7'h0, v});
		if (probe(sel) !== v)
			final_report();
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [7:0] d, rx;
		logic [2:0] ak;
		fails = 0;
		tests_run = 0;
		repeat (5) @(posedge clock_i);
		srst_i <= 1'b0;
		host_u.wr(7'h61, `HPC_REG_MUTE, 8'h00, ak);
		check("foreign ack", {5'h0, ak}, 8'h00);
		for (int r = 1; r <= 5; r++) begin
			host_u.rd(r[7:0], rx);
			check("reset value", rx, rst_tab[r]);
		end
		for (int i = 0; i < 4; i++) begin
			d = $random(seed);
			host_u.wr(`HPC_DEV_ADDR, `HPC_REG_MUTE, d, ak);
			check("ack", {5'h0, ak}, 8'h07);
			check("mute", {1'b0, left_mute_o, right_mute_o, volume_o}, {1'b0, d[7:1]});
			host_u.wr(`HPC_DEV_ADDR, `HPC_REG_OPT, d, ak);
			check("options", {5'h0, distortion_reduce_mode_o, left_hiz_o, right_hiz_o},
				{5'h0, d[3], d[1:0]});
			host_u.rd(`HPC_REG_OPT, rx);
			check("option read", rx, exp_rd(`HPC_REG_OPT, d));
			host_u.wr(`HPC_DEV_ADDR, `HPC_REG_PWR, d | 8'h01, ak);
			repeat (SD) @(posedge clock_i);
			host_u.rd(`HPC_REG_PWR, rx);
			check("mode read", rx, exp_rd(`HPC_REG_PWR, d | 8'h01));
			check("amps held off", {6'h0, left_amp_on_o, right_amp_on_o}, 8'h00);
		end
		host_u.wr(`HPC_DEV_ADDR, `HPC_REG_PWR, 8'hc0, ak);
		check("no ramp", {3'h0, soft_start_o, lim_seen}, 8'h00);
		host_u.wr(`HPC_DEV_ADDR, `HPC_REG_PWR, 8'hc1, ak);
		repeat (SD) @(posedge clock_i);
		@(posedge clock_i) supply_ok_i <= 1'b1;
		repeat (8) @(posedge clock_i);
		host_u.wr(`HPC_DEV_ADDR, `HPC_REG_PWR, 8'hc0, ak);
		check("ramp", {lim_seen[2:0], soft_start_o, 2'h0, cur_limit_o}, 8'he3);
		check("amps on", {6'h0, left_amp_on_o, right_amp_on_o}, 8'h03);
		host_u.wr(`HPC_DEV_ADDR, `HPC_REG_PWR, 8'h40, ak);
		check("right only", {6'h0, left_amp_on_o, right_amp_on_o}, 8'h01);
		wait_lvl(0, 1'b0, 4);
		@(posedge clock_i) begin
			out_high_i <= 1'b0;
			zero_cur_i <= 1'b0;
		end
		wait_lvl(0, 1'b1, 12);
		@(posedge clock_i) peak_over_i <= 1'b1;
		wait_lvl(1, 1'b1, 12);
		@(posedge clock_i) begin
			peak_over_i <= 1'b0;
			zero_cur_i <= 1'b1;
		end
		wait_lvl(1, 1'b0, 12);
		wait_lvl(0, 1'b1, 12);
		@(posedge clock_i) begin
			zero_cur_i <= 1'b0;
			out_high_i <= 1'b1;
		end
		wait_lvl(0, 1'b0, 12);
		wait_lvl(1, 1'b1, 12);
		@(posedge clock_i) zero_cur_i <= 1'b1;
		wait_lvl(1, 1'b0, 12);
		repeat (10) @(negedge clock_i);
		check("idle", {6'h0, high_sw_o, low_sw_o}, 8'h00);
		@(posedge clock_i) sig_high_i <= 1'b1;
		wait_lvl(2, 1'b1, 8);
		@(posedge clock_i) sig_high_i <= 1'b0;
		repeat (RH) @(negedge clock_i);
		check("rail held", {7'h0, rail_high_o}, 8'h01);
		wait_lvl(2, 1'b0, 16);
		host_u.wr(`HPC_DEV_ADDR, `HPC_REG_PWR, 8'hc1, ak);
		check("power-down", {4'h0, left_amp_on_o, right_amp_on_o, high_sw_o, low_sw_o},
			8'h00);
		repeat (SD) @(posedge clock_i);
		check("busy cycles", busy_n, {SD[6:0], 1'b0});
		final_report();
	end
endmodule // tb_headphone_amp_power_control
bind hpc_power_ctrl hpc_power_ctrl_asserts #(.RAIL_HOLD_CYC(RAIL_HOLD_CYC),
	.STEP_CYC(STEP_CYC), .PDN_CYC(PDN_CYC)) chk_u (.clock_i(clock_i), .srst_i(srst_i),
	.supply_ok_i(supply_ok_i), .sig_high_i(sig_high_i), .out_high_i(out_high_i),
	.zero_cur_i(zero_cur_i), .high_sw_o(high_sw_o), .low_sw_o(low_sw_o),
	.rail_high_o(rail_high_o), .cur_limit_o(cur_limit_o), .soft_start_o(soft_start_o),
	.left_amp_on_o(left_amp_on_o), .right_amp_on_o(right_amp_on_o),
	.shutdown_busy_o(shutdown_busy_o));
`default_nettype wire
